/* rtl/sfw_ctrl.sv */
// serial flash command interpreter for write enable, identification, status and protection
//
// Behaviour
// - write-enable command framed alone sets the write enable latch
// - write-disable command framed alone clears the write enable latch
// - latch clears at reset and on completion of any modifying command
// - identification shifts out manufacturer byte then two device bytes, 24 bits
// - identification not decoded while busy; busy cycle untouched; standby at deselect
// - status read accepted anytime; status byte repeats while selected
// - status byte: disable 7, quad 6, protect 5..2, latch 1, busy 0
// - busy flag is 1 during program, erase or status write, else 0
// - program, erase and status write refused while latch is 0
// - program or erase aimed at protected area is ignored
// - protect bits change only by status write or reset (cleared); chip erase needs them zero
// - quad enable 0 makes shared pin write-protect; 1 gives quad lines
// - disable flag set with protect pin low blocks status writes
// - status write updates bits 7..2 only, never latch or busy
// - status write is command plus exactly one byte, else rejected
// - status write cycle starts at deselect, busy throughout, then clears latch
// - software protection allows status write when latch is set
// - four-line read mode disables hardware protection
`timescale 1ns/1ns
module sfw_ctrl
	import sfw_pkg::*;
#(
	parameter int unsigned STATUS_WRITE_CYCLES_P = sfw_pkg::STATUS_WRITE_CYCLES,
	parameter logic [7:0] WRITE_ENABLE_CMD = 8'h06,
	parameter logic [7:0] WRITE_DISABLE_CMD = 8'h04,
	parameter logic [7:0] IDENTIFICATION_READ_CMD = 8'h9F,
	parameter logic [7:0] STATUS_READ_CMD = 8'h05,
	parameter logic [7:0] STATUS_WRITE_CMD = 8'h01,
	// identification bytes: arbitrary values
	parameter logic [7:0] MANUFACTURER_CODE = 8'h5A,
	parameter logic [7:0] MEMORY_TYPE_CODE = 8'h3C,
	parameter logic [7:0] DEVICE_CODE = 8'h15
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// serial pins
	input wire logic cs_n_i,
	input wire logic sclk_i,
	input wire logic si_i,
	output logic so_o,
	output logic so_oe_n_o,
	input wire logic protect_pin_io2_i,
	// array operation port
	output logic op_start_o,
	output sfw_pkg::sfw_op_t op_kind_o,
	output logic [23:0] op_addr_o,
	input wire logic op_done_i,
	input wire logic area_protected_i,
	input wire logic quad_read_active_i,
	// status view
	output logic [3:0] block_protect_o,
	output logic quad_enable_o,
	output logic hw_protect_o,
	output logic busy_o
);

	import sfw_pkg::*;

	// ==========================================
	// reset release
	logic [1:0] rst_sync_q;
	logic rst_n;

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			rst_sync_q <= 2'h0;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end

	assign rst_n = rst_sync_q[1];

	// ==========================================
	// pin synchronisers
	logic cs_n_s;
	logic sclk_s;
	logic si_s;
	logic wp_s;

	sfw_sync #(
		.W(4),
		.RST_VAL(4'h9)
	) u_sync (
		.clk_i(clk_i),
		.rst_n_i(rst_n),
		.d_i({cs_n_i, sclk_i, si_i, protect_pin_io2_i}),
		.q_o({cs_n_s, sclk_s, si_s, wp_s})
	);

	// ==========================================
	// state
	typedef struct packed {
		sfw_state_t st;
		logic cs_prev;
		logic sclk_prev;
		logic [2:0] bitcnt;
		logic [1:0] bytecnt;
		logic [7:0] shin;
		logic [7:0] cmd;
		logic [23:0] addr;
		logic [7:0] out_sh;
		logic [2:0] outcnt;
		logic [1:0] id_idx;
		logic so;
		logic so_oe_n;
		logic [7:0] sr;
		logic [7:0] sr_pend;
		logic write_enable_latch;
		logic wsr_busy;
		logic [31:0] wsr_cnt;
		logic op_busy;
		logic op_start;
		sfw_op_t op_kind;
	} sfw_ctrl_t;

	sfw_ctrl_t q, n;

	logic sclk_rise;
	logic sclk_fall;
	logic cs_fall;
	logic cs_rise;
	logic busy;
	logic hardware_protection_mode;
	logic [7:0] byte_in;
	logic [7:0] status_byte;
	logic [7:0] id_next;

	assign busy = q.wsr_busy | q.op_busy;
	// the shared pin only guards when it is not a quad line and no quad read is on
	assign hardware_protection_mode = q.sr[SR_STATUS_WRITE_DISABLE_BIT] & ~wp_s & ~q.sr[SR_QE_BIT] & ~quad_read_active_i;

	always_comb
	begin
		status_byte = q.sr;
		status_byte[SR_WEL_BIT] = q.write_enable_latch;
		status_byte[SR_BUSY_BIT] = busy;
	end

	always_comb
	begin
		n = q;
		n.op_start = 1'b0;
		sclk_rise = sclk_s & ~q.sclk_prev;
		sclk_fall = ~sclk_s & q.sclk_prev;
		cs_fall = ~cs_n_s & q.cs_prev;
		cs_rise = cs_n_s & ~q.cs_prev;
		byte_in = {q.shin[6:0], si_s};
		id_next = (q.id_idx == 2'h0) ? MEMORY_TYPE_CODE : DEVICE_CODE;
		n.sclk_prev = sclk_s;
		n.cs_prev = cs_n_s;

		// self-timed cycles run regardless of the serial traffic
		if (q.op_busy && op_done_i)
		begin
			n.op_busy = 1'b0;
			n.write_enable_latch = 1'b0;
		end
		if (q.wsr_busy)
		begin
			if (q.wsr_cnt == 32'h0)
			begin
				n.wsr_busy = 1'b0;
				n.write_enable_latch = 1'b0;
				n.sr = (q.sr & ~SR_WRITABLE_MASK) | (q.sr_pend & SR_WRITABLE_MASK);
			end
			else
				n.wsr_cnt = q.wsr_cnt - 32'h1;
		end

		if (cs_fall)
		begin
			n.st = ST_CMD;
			n.bitcnt = 3'h0;
			n.bytecnt = 2'h0;
			n.so_oe_n = 1'b1;
		end
		else if (cs_rise)
		begin
			// partial frames end here without effect
			n.st = ST_IDLE;
			n.so_oe_n = 1'b1;
			case (q.st)
				ST_TAIL:
				begin
					if (q.cmd == WRITE_ENABLE_CMD)
						n.write_enable_latch = 1'b1;
					else if (q.cmd == WRITE_DISABLE_CMD)
						n.write_enable_latch = 1'b0;
					else if (q.cmd == STATUS_WRITE_CMD)
					begin
						if (q.write_enable_latch && !hardware_protection_mode)
						begin
							n.wsr_busy = 1'b1;
							n.wsr_cnt = 32'(STATUS_WRITE_CYCLES_P - 1);
						end
					end
					else if (q.cmd == CHIP_ERASE_CMD_A || q.cmd == CHIP_ERASE_CMD_B)
					begin
						if (q.write_enable_latch && q.sr[SR_BP_MSB:SR_BP_LSB] == 4'h0)
						begin
							n.op_busy = 1'b1;
							n.op_start = 1'b1;
							n.op_kind = OP_CHIP;
						end
					end
					else if (q.write_enable_latch && !area_protected_i)
					begin
						n.op_busy = 1'b1;
						n.op_start = 1'b1;
						n.op_kind = (q.cmd == SECTOR_ERASE_CMD) ? OP_SECTOR : OP_BLOCK;
					end
				end
				ST_PPDATA:
				begin
					if (q.bitcnt == 3'h0 && q.bytecnt != 2'h0 && q.write_enable_latch && !area_protected_i)
					begin
						n.op_busy = 1'b1;
						n.op_start = 1'b1;
						n.op_kind = (q.cmd == QUAD_PAGE_PROGRAM_CMD) ? OP_QUAD_PAGE : OP_PAGE;
					end
				end
				default:
				begin
				end
			endcase
		end
		else if (!cs_n_s && sclk_rise)
		begin
			n.shin = byte_in;
			n.bitcnt = q.bitcnt + 3'h1;
			case (q.st)
				ST_CMD:
				begin
					if (q.bitcnt == 3'h7)
					begin
						n.cmd = byte_in;
						n.bytecnt = 2'h0;
						n.outcnt = 3'h0;
						if (byte_in == STATUS_READ_CMD)
						begin
							n.st = ST_STAT;
							n.out_sh = status_byte;
						end
						else if (busy)
							n.st = ST_IGNORE;
						else if (byte_in == IDENTIFICATION_READ_CMD)
						begin
							n.st = ST_ID;
							n.out_sh = MANUFACTURER_CODE;
							n.id_idx = 2'h0;
						end
						else if (byte_in == WRITE_ENABLE_CMD || byte_in == WRITE_DISABLE_CMD ||
							byte_in == CHIP_ERASE_CMD_A || byte_in == CHIP_ERASE_CMD_B)
							n.st = ST_TAIL;
						else if (byte_in == STATUS_WRITE_CMD)
							n.st = ST_WRDATA;
						else if (byte_in == PAGE_PROGRAM_CMD || byte_in == QUAD_PAGE_PROGRAM_CMD ||
							byte_in == SECTOR_ERASE_CMD || byte_in == BLOCK_ERASE_CMD)
							n.st = ST_ADDR;
						else
							n.st = ST_IGNORE;
					end
				end
				ST_TAIL:
					// any clock after the last expected bit breaks the byte boundary
					n.st = ST_IGNORE;
				ST_WRDATA:
				begin
					if (q.bitcnt == 3'h7)
					begin
						n.sr_pend = byte_in;
						n.st = ST_TAIL;
					end
				end
				ST_ADDR:
				begin
					if (q.bitcnt == 3'h7)
					begin
						n.addr = {q.addr[15:0], byte_in};
						n.bytecnt = q.bytecnt + 2'h1;
						if (q.bytecnt == 2'(ADDR_BYTES - 1))
						begin
							n.bytecnt = 2'h0;
							n.st = (q.cmd == SECTOR_ERASE_CMD || q.cmd == BLOCK_ERASE_CMD) ? ST_TAIL : ST_PPDATA;
						end
					end
				end
				ST_PPDATA:
				begin
					// data bytes are not stored or passed on; only a boundary flag is kept here
					if (q.bitcnt == 3'h7)
						n.bytecnt = 2'h1;
				end
				default:
				begin
				end
			endcase
		end
		else if (!cs_n_s && sclk_fall)
		begin
			case (q.st)
				ST_STAT, ST_ID:
				begin
					n.so = q.out_sh[7];
					n.so_oe_n = 1'b0;
					n.outcnt = q.outcnt + 3'h1;
					n.out_sh = {q.out_sh[6:0], 1'b0};
					if (q.outcnt == 3'h7)
					begin
						if (q.st == ST_STAT)
							n.out_sh = status_byte;
						else
						begin
							n.out_sh = id_next;
							n.id_idx = q.id_idx + 2'h1;
							if (q.id_idx == 2'(ID_BYTES - 1))
								n.st = ST_IDEND;
						end
					end
				end
				ST_IDEND:
				begin
					n.so_oe_n = 1'b1;
					n.st = ST_IGNORE;
				end
				default:
				begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			q <= '0;
			q.st <= ST_IDLE;
			q.cs_prev <= 1'b1;
			q.so_oe_n <= 1'b1;
			q.sr <= SR_RESET;
			q.write_enable_latch <= 1'b0;
			q.op_kind <= OP_PAGE;
		end
		else
			q <= n;
	end

	// ==========================================
	// outputs
	assign so_o = q.so;
	assign so_oe_n_o = q.so_oe_n;
	assign op_start_o = q.op_start;
	assign op_kind_o = q.op_kind;
	assign op_addr_o = q.addr;
	assign block_protect_o = q.sr[SR_BP_MSB:SR_BP_LSB];
	assign quad_enable_o = q.sr[SR_QE_BIT];
	assign hw_protect_o = hardware_protection_mode;
	assign busy_o = busy;

endmodule

/* rtl/sfw_pkg.sv */
// shared constants and types of the serial flash write-protect controller
package sfw_pkg;

	// ==========================================
	// clock and timing
	localparam int unsigned CLK_FREQ_MHZ = 100;
	// self-timed status write cycle, in microseconds
	localparam int unsigned STATUS_WRITE_CYCLE_TIME_US = 10000;
	localparam int unsigned STATUS_WRITE_CYCLES = STATUS_WRITE_CYCLE_TIME_US * CLK_FREQ_MHZ;

	// ==========================================
	// protection_status field layout
	localparam int unsigned SR_BUSY_BIT = 0;
	localparam int unsigned SR_WEL_BIT = 1;
	localparam int unsigned SR_BP_LSB = 2;
	localparam int unsigned SR_BP_MSB = 5;
	localparam int unsigned SR_QE_BIT = 6;
	localparam int unsigned SR_STATUS_WRITE_DISABLE_BIT = 7;
	localparam logic [7:0] SR_RESET = 8'h00;
	localparam logic [7:0] SR_WRITABLE_MASK = 8'hFC;

	// ==========================================
	// command codes of the array operations
	localparam logic [7:0] PAGE_PROGRAM_CMD = 8'h02;
	localparam logic [7:0] QUAD_PAGE_PROGRAM_CMD = 8'h38;
	localparam logic [7:0] SECTOR_ERASE_CMD = 8'h20;
	localparam logic [7:0] BLOCK_ERASE_CMD = 8'hD8;
	localparam logic [7:0] CHIP_ERASE_CMD_A = 8'h60;
	localparam logic [7:0] CHIP_ERASE_CMD_B = 8'hC7;

	// ==========================================
	// framing
	localparam int unsigned ADDR_BYTES = 3;
	localparam int unsigned ID_BYTES = 3;

	// ==========================================
	// types
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_CMD,
		ST_TAIL,
		ST_WRDATA,
		ST_ADDR,
		ST_PPDATA,
		ST_STAT,
		ST_ID,
		ST_IDEND,
		ST_IGNORE
	} sfw_state_t;

	typedef enum logic [2:0] {
		OP_PAGE,
		OP_QUAD_PAGE,
		OP_SECTOR,
		OP_BLOCK,
		OP_CHIP
	} sfw_op_t;

endpackage

/* rtl/sfw_sync.sv */
// three-flop pin synchroniser with agreement filter
`timescale 1ns/1ns
module sfw_sync #(
	parameter int unsigned W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// pins and filtered copy
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] val;
	} sfw_sync_t;

	sfw_sync_t q, n;

	// a bit changes only once stages two and three agree
	always_comb
	begin
		n = q;
		n.s1 = d_i;
		n.s2 = q.s1;
		n.s3 = q.s2;
		n.val = (q.s2 & q.s3) | (q.val & (q.s2 | q.s3));
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			q <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
		else
			q <= n;
	end

	assign q_o = q.val;

endmodule

/* sim/sfw_ctrl_assertions.sv */
// concurrent checks on the ports of the serial flash write-protect controller
`timescale 1ns/1ns
module sfw_ctrl_chk
	import sfw_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// pins
	input wire logic cs_n_i,
	input wire logic so_oe_n_o,
	input wire logic quad_read_active_i,
	input wire logic area_protected_i,
	// array port and status view
	input wire logic op_start_o,
	input wire sfw_pkg::sfw_op_t op_kind_o,
	input wire logic [3:0] block_protect_o,
	input wire logic quad_enable_o,
	input wire logic hw_protect_o,
	input wire logic busy_o
);
	// ====================
	// checks
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!arst_n_i);
	oe_release_a: assert property ($rose(cs_n_i) |-> ##[1:8] so_oe_n_o)
		else $error("data out still driven after deselect");
	oe_start_a: assert property ($fell(so_oe_n_o) |-> !cs_n_i)
		else $error("data out driven while deselected");
	start_pulse_a: assert property (op_start_o |=> !op_start_o)
		else $error("start pulse longer than one cycle");
	start_busy_a: assert property (op_start_o |-> ##[0:1] busy_o)
		else $error("busy missing after start");
	start_idle_a: assert property (op_start_o |-> !$past(busy_o, 2))
		else $error("operation started while busy");
	area_guard_a: assert property (op_start_o && op_kind_o != OP_CHIP |-> !area_protected_i)
		else $error("protected area modified");
	chip_guard_a: assert property (op_start_o && op_kind_o == OP_CHIP |-> block_protect_o == 4'h0)
		else $error("chip erase with protect bits set");
	bits_stable_a: assert property (!$stable({quad_enable_o, block_protect_o}) |-> $past(busy_o))
		else $error("status bits changed outside a write cycle");
	hw_mode_a: assert property (hw_protect_o |-> !quad_enable_o && !quad_read_active_i)
		else $error("hardware protection in quad mode");
endmodule
bind sfw_ctrl sfw_ctrl_chk chk_u (.clk_i, .arst_n_i, .cs_n_i, .so_oe_n_o, .quad_read_active_i, .area_protected_i,
	.op_start_o, .op_kind_o, .block_protect_o, .quad_enable_o, .hw_protect_o, .busy_o);

/* sim/sfw_host.sv */
// host-side serial controller model driving the flash pins
`timescale 1ns/1ns
module sfw_host (
	// clock
	input wire logic clk_i,
	// serial pins
	output logic cs_n_o,
	output logic sclk_o,
	output logic si_o,
	input wire logic so_i
);
	initial
	begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		si_o = 1'b0;
	end
	// ====================
	// one frame: nb whole bytes msb first, then nr clocks reading data out
	task automatic run(input int nb, input logic [39:0] tx, input int nr, output logic [23:0] rx);
		rx = '0;
		@(posedge clk_i) cs_n_o <= 1'b0;
		repeat (8) @(posedge clk_i);
		for (int i = 0; i < nb * 8 + nr; i++)
		begin
			// idle data toggles so a stale level never passes for data
			si_o <= (i < nb * 8) ? tx[39 - i] : ~si_o;
			repeat (4) @(posedge clk_i);
			sclk_o <= 1'b1;
			repeat (4) @(posedge clk_i);
			if (i >= nb * 8)
				rx = {rx[22:0], so_i};
			sclk_o <= 1'b0;
		end
		repeat (4) @(posedge clk_i);
		cs_n_o <= 1'b1;
		si_o <= ~si_o;
		repeat (12) @(posedge clk_i);
	endtask
endmodule

/* sim/sfw_ctrl_tb.sv */
// self-checking bench of the serial flash write-protect controller
`timescale 1ns/1ns
module sfw_ctrl_tb;
	import sfw_pkg::*;
	typedef struct {logic [2:0] md; int nb; logic [39:0] tx; int nr; logic [7:0] ex;} sfw_row_t;
	logic clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	wire cs_n_i;
	wire sclk_i;
	wire si_i;
	logic protect_pin_io2_i = 1'b1;
	logic area_protected_i = 1'b0;
	logic quad_read_active_i = 1'b0;
	logic op_done_i = 1'b0;
	logic so_o, so_oe_n_o, op_start_o, quad_enable_o, hw_protect_o, busy_o, oe_seen;
	sfw_op_t op_kind_o;
	sfw_op_t kind_seen;
	logic [23:0] op_addr_o, rx;
	logic [3:0] block_protect_o;
	int failures = 0;
	int checks_done = 0;
	int done_cnt = 0;
	// mode is {area protected, protect pin, four-line read}; writes use the latch left by an earlier row, row 2 runs with it clear
	sfw_row_t rows [25] = '{
		'{3'b010, 1, 40'h0600000000, 0, 8'h02}, '{3'b010, 1, 40'h0400000000, 0, 8'h00},
		'{3'b010, 2, 40'h013C000000, 0, 8'h00}, '{3'b010, 1, 40'h0600000000, 0, 8'h02},
		'{3'b010, 2, 40'h013F000000, 0, 8'h3C}, '{3'b010, 1, 40'h0600000000, 0, 8'h3E},
		'{3'b010, 1, 40'hC700000000, 0, 8'h3E}, '{3'b010, 2, 40'h013C000000, 3, 8'h3E},
		'{3'b010, 2, 40'h0180000000, 0, 8'h80}, '{3'b000, 1, 40'h0600000000, 0, 8'h82},
		'{3'b000, 2, 40'h0100000000, 0, 8'h82}, '{3'b001, 2, 40'h0100000000, 0, 8'h00},
		'{3'b010, 1, 40'h0600000000, 0, 8'h02}, '{3'b110, 4, 40'h2000100000, 0, 8'h02},
		'{3'b010, 4, 40'h2000100000, 0, 8'h00}, '{3'b010, 1, 40'h0600000000, 0, 8'h02},
		'{3'b010, 1, 40'h6000000000, 0, 8'h00}, '{3'b010, 1, 40'h0600000000, 0, 8'h02},
		'{3'b010, 2, 40'h01C0000000, 0, 8'hC0}, '{3'b000, 1, 40'h0600000000, 0, 8'hC2},
		'{3'b000, 2, 40'h0100000000, 0, 8'h00}, '{3'b010, 1, 40'h0600000000, 0, 8'h02},
		'{3'b010, 4, 40'hD800010000, 0, 8'h00}, '{3'b010, 1, 40'h0600000000, 0, 8'h02},
		'{3'b010, 5, 40'h38000100A5, 0, 8'h00}};
	// a released data line reads as the inverse, so an undriven bit never passes for data
	sfw_host host_u (.clk_i, .cs_n_o(cs_n_i), .sclk_o(sclk_i), .si_o(si_i), .so_i(so_oe_n_o ? ~so_o : so_o));
	sfw_ctrl #(.STATUS_WRITE_CYCLES_P(20)) dut_u (.clk_i, .arst_n_i, .cs_n_i, .sclk_i, .si_i, .so_o, .so_oe_n_o,
		.protect_pin_io2_i, .op_start_o, .op_kind_o, .op_addr_o, .op_done_i, .area_protected_i,
		.quad_read_active_i, .block_protect_o, .quad_enable_o, .hw_protect_o, .busy_o);
	always #5 clk_i = ~clk_i;
	// ====================
	// array path: finishes a fixed time after each start
	always @(posedge clk_i)
	begin
		done_cnt <= (op_start_o === 1'b1) ? 600 : (done_cnt > 0 ? done_cnt - 1 : 0);
		op_done_i <= (done_cnt == 1);
		if (so_oe_n_o === 1'b0)
			oe_seen <= 1'b1;
		if (op_start_o === 1'b1)
			kind_seen <= op_kind_o;
	end
	// ====================
	// helpers
	task automatic complete_run();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [23:0] ex, input logic [23:0] got);
		checks_done++;
		if (got !== ex)
		begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task automatic wait_idle();
		for (int n = 0; busy_o !== 1'b0; n++)
		begin
			if (n > 3000)
			begin
				failures++;
				complete_run();
			end
			@(posedge clk_i);
		end
	endtask
	// ====================
	// sequence
	initial
	begin
		repeat (20) @(posedge clk_i);
		arst_n_i <= 1'b1;
		repeat (10) @(posedge clk_i);
		foreach (rows[k])
		begin
			{area_protected_i, protect_pin_io2_i, quad_read_active_i} <= rows[k].md;
			host_u.run(rows[k].nb, rows[k].tx, rows[k].nr, rx);
			wait_idle();
			host_u.run(1, 40'h0500000000, 8, rx);
			chk("status", {16'h0, rows[k].ex}, rx);
			$display("row %0d done", k);
		end
		chk("kind", OP_QUAD_PAGE, kind_seen);
		chk("address", 24'h000100, op_addr_o);
		host_u.run(1, 40'h9F00000000, 24, rx);
		chk("ident", 24'h5A3C15, rx);
		$display("ident done");
		host_u.run(1, 40'h0600000000, 0, rx);
		host_u.run(5, 40'h02012345A5, 0, rx);
		host_u.run(1, 40'h0500000000, 8, rx);
		chk("busy status", 24'h03, rx);
		chk("kind", OP_PAGE, kind_seen);
		chk("address", 24'h012345, op_addr_o);
		oe_seen = 1'b0;
		host_u.run(1, 40'h9F00000000, 24, rx);
		chk("ident while busy", 24'h0, oe_seen);
		wait_idle();
		host_u.run(1, 40'h0500000000, 8, rx);
		chk("after program", 24'h0, rx);
		$display("busy done");
		host_u.run(1, 40'h0600000000, 0, rx);
		arst_n_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		arst_n_i <= 1'b1;
		repeat (10) @(posedge clk_i);
		host_u.run(1, 40'h0500000000, 8, rx);
		chk("after reset", 24'h0, rx);
		$display("reset done");
		complete_run();
	end
endmodule
